// >>> verilog/cfg_regs_pkg.sv
// Register map, field layout and decode constants for the drive configuration words
package cfg_regs_pkg;
  localparam logic [7:0] PROT_ADDR = 8'h94;
  localparam logic [7:0] DRIVE_ADDR = 8'h95;
  localparam logic [15:0] PROT_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_RESET = 16'h0000;

  // Protection word field positions
  localparam int OT_CLAMP_LSB = 14;
  localparam int CL_STUCK_BIT = 13;
  localparam int OL_STUCK_BIT = 12;
  localparam int ABSENT_BIT = 11;
  localparam int TORQUE_BIT = 10;
  localparam int SPEED_BIT = 9;
  localparam int LOCKCUR_BIT = 8;
  localparam int SW_LIMIT_LSB = 4;
  localparam int LOCK_LIMIT_LSB = 1;
  localparam int LOCK_RANGE_BIT = 0;

  // Drive word field positions
  localparam int SPEED_TYPE_BIT = 15;
  localparam int PWM_RATE_BIT = 14;
  localparam int TQ_BOUNDS_LSB = 12;
  localparam int IND_SURGE_BIT = 11;
  localparam int MECH_SURGE_BIT = 10;
  localparam int MECH_REF_BIT = 9;
  localparam int RELEASE_BIT = 8;
  localparam int CL_INHIBIT_BIT = 7;
  localparam int RAMP_LSB = 4;
  localparam int DUTY_LSB = 2;
  localparam int EDGE_LSB = 0;

  // Currents in units of 0.1 A
  localparam logic [7:0] OT_CLAMP_1A = 8'h0a;
  localparam logic [7:0] OT_CLAMP_1A6 = 8'h10;
  localparam logic [7:0] OT_CLAMP_2A = 8'h14;
  localparam logic [7:0] LOCK_2A5 = 8'h19;
  localparam logic [7:0] LOCK_1A9 = 8'h13;
  localparam logic [7:0] LOCK_1A5 = 8'h0f;
  localparam logic [7:0] LOCK_0A9 = 8'h09;
  localparam logic [7:0] STEP_0A2 = 8'h02;
  localparam logic [7:0] STEP_0A4 = 8'h04;

  // Torque bounds in quarters of nominal
  localparam logic [3:0] TQ_HIGH_3_2 = 4'h6;
  localparam logic [3:0] TQ_HIGH_2 = 4'h8;
  localparam logic [3:0] TQ_LOW_3_4 = 4'h3;
  localparam logic [3:0] TQ_LOW_1_2 = 4'h2;

  // Duty floors and cutoff in tenths of a percent
  localparam logic [9:0] DUTY_FLOOR_5 = 10'h032;
  localparam logic [9:0] DUTY_FLOOR_10 = 10'h064;
  localparam logic [9:0] DUTY_CUTOFF = 10'h00f;
  localparam logic [9:0] DUTY_FULL = 10'h3e8;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic ot_clamp_on;
    logic [7:0] ot_clamp_dA;
    logic closed_loop_stuck_arm;
    logic open_loop_stuck_arm;
    logic absent_motor_arm;
    logic torque_const_fault_arm;
    logic speed_fault_arm;
    logic lock_current_arm;
    logic sw_limit_on;
    logic [7:0] sw_limit_dA;
    logic [7:0] lock_limit_dA;
  } prot_cfg_t;

  typedef struct packed {
    logic speed_input_pwm;
    logic output_pwm_50k;
    logic [3:0] torque_high_q;
    logic [3:0] torque_low_q;
    logic inductive_surge_guard_on;
    logic mechanical_surge_guard_on;
    logic mechanical_surge_to_24v;
    logic release_hiz;
    logic closed_loop_inhibit;
    logic ramp_immediate;
    logic [2:0] closed_loop_ramp;
    logic [9:0] duty_floor;
    logic duty_low_full;
    logic [1:0] phase_edge_rate;
  } drive_cfg_t;
endpackage

// >>> verilog/cfg_word_reg.sv
// One 16-bit read/write configuration word with address match
`timescale 1ns/1ps
module cfg_word_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Write port
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  // Address match and stored word
  output logic hit_o,
  output logic [15:0] q_o
);
  logic [15:0] word_ff;
  logic [15:0] nxt_word;

  assign hit_o = (addr_i == ADDR);
  assign nxt_word = (wr_i && hit_o) ? wdata_i : word_ff;
  assign q_o = word_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_ff <= RESET_VAL;
    end else if (ce_i) begin
      word_ff <= nxt_word;
    end
  end
endmodule

// >>> verilog/motor_protect_drive_config_regs.sv
// Protection and drive configuration words with decoded settings
`timescale 1ns/1ps
module motor_protect_drive_config_regs (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register port from the serial interface
  input wire cfg_regs_pkg::reg_req_t req_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic rerr_o,
  // Duty shaping path
  input wire logic [9:0] duty_cmd_i,
  output logic [9:0] duty_out_o,
  // Decoded settings
  output cfg_regs_pkg::prot_cfg_t prot_o,
  output cfg_regs_pkg::drive_cfg_t drive_o
);
  import cfg_regs_pkg::*;

  logic [15:0] prot_word;
  logic [15:0] drive_word;
  logic prot_hit;
  logic drive_hit;

  cfg_word_reg #(
    .ADDR(PROT_ADDR),
    .RESET_VAL(PROT_RESET)
  ) u_prot (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .wr_i(req_i.wr),
    .addr_i(req_i.addr),
    .wdata_i(req_i.wdata),
    .hit_o(prot_hit),
    .q_o(prot_word)
  );

  cfg_word_reg #(
    .ADDR(DRIVE_ADDR),
    .RESET_VAL(DRIVE_RESET)
  ) u_drive (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .wr_i(req_i.wr),
    .addr_i(req_i.addr),
    .wdata_i(req_i.wdata),
    .hit_o(drive_hit),
    .q_o(drive_word)
  );

  // Read mux; unmapped reads return zero with error flag
  wire [15:0] nxt_rdata = prot_hit ? prot_word : (drive_hit ? drive_word : 16'h0000);
  wire nxt_rerr = req_i.rd && !prot_hit && !drive_hit;

  // Protection field slices
  wire [1:0] ot_code = prot_word[OT_CLAMP_LSB +: 2];
  wire [3:0] sw_code = prot_word[SW_LIMIT_LSB +: 4];
  wire [2:0] lock_code = prot_word[LOCK_LIMIT_LSB +: 3];
  wire lock_range = prot_word[LOCK_RANGE_BIT];

  wire [7:0] ot_dA = (ot_code == 2'h1) ? OT_CLAMP_1A :
                     (ot_code == 2'h2) ? OT_CLAMP_1A6 :
                     (ot_code == 2'h3) ? OT_CLAMP_2A : 8'h00;
  wire [7:0] sw_dA = 8'({4'h0, sw_code} * STEP_0A2);
  wire [7:0] lock_low_dA = (lock_code[1:0] == 2'h0) ? LOCK_2A5 :
                           (lock_code[1:0] == 2'h1) ? LOCK_1A9 :
                           (lock_code[1:0] == 2'h2) ? LOCK_1A5 : LOCK_0A9;
  wire [7:0] lock_high_dA = 8'({5'h00, lock_code} * STEP_0A4 + STEP_0A4);
  wire [7:0] lock_dA = lock_range ? lock_high_dA : lock_low_dA;

  prot_cfg_t nxt_prot;
  assign nxt_prot.ot_clamp_on = (ot_code != 2'h0);
  assign nxt_prot.ot_clamp_dA = ot_dA;
  assign nxt_prot.closed_loop_stuck_arm = prot_word[CL_STUCK_BIT];
  assign nxt_prot.open_loop_stuck_arm = prot_word[OL_STUCK_BIT];
  assign nxt_prot.absent_motor_arm = prot_word[ABSENT_BIT];
  assign nxt_prot.torque_const_fault_arm = prot_word[TORQUE_BIT];
  assign nxt_prot.speed_fault_arm = prot_word[SPEED_BIT];
  assign nxt_prot.lock_current_arm = prot_word[LOCKCUR_BIT];
  assign nxt_prot.sw_limit_on = (sw_code != 4'h0);
  assign nxt_prot.sw_limit_dA = sw_dA;
  assign nxt_prot.lock_limit_dA = lock_dA;

  // Drive field slices
  wire [1:0] tq_code = drive_word[TQ_BOUNDS_LSB +: 2];
  wire [2:0] ramp_code = drive_word[RAMP_LSB +: 3];
  wire [1:0] duty_code = drive_word[DUTY_LSB +: 2];
  wire [9:0] floor_sel = duty_code[0] ? DUTY_FLOOR_10 : DUTY_FLOOR_5;

  drive_cfg_t nxt_drive;
  assign nxt_drive.speed_input_pwm = drive_word[SPEED_TYPE_BIT];
  assign nxt_drive.output_pwm_50k = drive_word[PWM_RATE_BIT];
  assign nxt_drive.torque_high_q = tq_code[0] ? TQ_HIGH_2 : TQ_HIGH_3_2;
  assign nxt_drive.torque_low_q = tq_code[1] ? TQ_LOW_1_2 : TQ_LOW_3_4;
  assign nxt_drive.inductive_surge_guard_on = drive_word[IND_SURGE_BIT];
  assign nxt_drive.mechanical_surge_guard_on = drive_word[MECH_SURGE_BIT];
  assign nxt_drive.mechanical_surge_to_24v = drive_word[MECH_REF_BIT];
  assign nxt_drive.release_hiz = drive_word[RELEASE_BIT];
  assign nxt_drive.closed_loop_inhibit = drive_word[CL_INHIBIT_BIT];
  assign nxt_drive.ramp_immediate = (ramp_code == 3'h0);
  assign nxt_drive.closed_loop_ramp = ramp_code;
  assign nxt_drive.duty_floor = floor_sel;
  assign nxt_drive.duty_low_full = duty_code[1];
  assign nxt_drive.phase_edge_rate = drive_word[EDGE_LSB +: 2];

  // Duty shaping: linear above floor, floor down to cutoff, then 0 or full
  wire duty_below_cut = (duty_cmd_i < DUTY_CUTOFF);
  wire duty_below_floor = (duty_cmd_i < floor_sel);
  wire [9:0] duty_low_val = duty_code[1] ? DUTY_FULL : 10'h000;
  wire [9:0] nxt_duty = duty_below_cut ? duty_low_val :
                        (duty_below_floor ? floor_sel : duty_cmd_i);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
      rerr_o <= 1'b0;
    end else if (ce_i) begin
      rvalid_o <= req_i.rd;
      rerr_o <= nxt_rerr;
      if (req_i.rd) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prot_o <= '0;
      drive_o <= '0;
      duty_out_o <= 10'h000;
    end else if (ce_i) begin
      prot_o <= nxt_prot;
      drive_o <= nxt_drive;
      duty_out_o <= nxt_duty;
    end
  end
endmodule

// >>> verification/cfg_regs_checker.sv
// Concurrent checks on the configuration word block ports
`timescale 1ns/1ps
module cfg_regs_checker (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register and duty ports
  input wire cfg_regs_pkg::reg_req_t req_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic rerr_o,
  input wire logic [9:0] duty_cmd_i,
  input wire logic [9:0] duty_out_o,
  // Decoded settings
  input wire cfg_regs_pkg::prot_cfg_t prot_o,
  input wire cfg_regs_pkg::drive_cfg_t drive_o
);
  import cfg_regs_pkg::*;
  wire quiet;
  assign quiet = ce_i && !req_i.wr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  rd_answer_a: assert property (ce_i && req_i.rd |=> rvalid_o)
    else $error("read not answered");
  no_spurious_a: assert property (ce_i && !req_i.rd |=> !rvalid_o)
    else $error("answer without read");
  bad_addr_a: assert property (ce_i && req_i.rd && req_i.addr != PROT_ADDR
    && req_i.addr != DRIVE_ADDR |=> rerr_o && rdata_o == 16'h0000) else $error("bad read");
  good_addr_a: assert property (ce_i && req_i.rd && req_i.addr == PROT_ADDR |=> !rerr_o)
    else $error("error on mapped read");
  duty_cut_a: assert property (quiet && $past(quiet) && duty_cmd_i < DUTY_CUTOFF
    |=> duty_out_o == (drive_o.duty_low_full ? DUTY_FULL : 10'h000)) else $error("cutoff");
  duty_floor_a: assert property (quiet && $past(quiet) && duty_cmd_i >= DUTY_CUTOFF
    && duty_cmd_i < drive_o.duty_floor |=> duty_out_o == drive_o.duty_floor) else $error("floor");
  duty_pass_a: assert property (quiet && $past(quiet) && duty_cmd_i >= drive_o.duty_floor
    |=> duty_out_o == $past(duty_cmd_i)) else $error("duty not linear");
  drive_dec_a: assert property (ce_i && req_i.wr && req_i.addr == DRIVE_ADDR ##1 ce_i
    |=> {drive_o.closed_loop_ramp, drive_o.phase_edge_rate} == {$past(req_i.wdata[6:4], 2),
    $past(req_i.wdata[1:0], 2)}) else $error("drive decode");
  prot_arm_a: assert property (ce_i && req_i.wr && req_i.addr == PROT_ADDR ##1 ce_i
    |=> {prot_o.closed_loop_stuck_arm, prot_o.open_loop_stuck_arm, prot_o.absent_motor_arm,
    prot_o.torque_const_fault_arm, prot_o.speed_fault_arm, prot_o.lock_current_arm}
    == $past(req_i.wdata[13:8], 2)) else $error("arm bits");
endmodule
bind motor_protect_drive_config_regs cfg_regs_checker chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rerr_o(rerr_o),
  .duty_cmd_i(duty_cmd_i), .duty_out_o(duty_out_o), .prot_o(prot_o), .drive_o(drive_o));

// >>> verification/tb_motor_protect_drive_config_regs.sv
// Self-checking bench for the configuration word block
`timescale 1ns/1ps
module tb_motor_protect_drive_config_regs;
  import cfg_regs_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  reg_req_t req = '0;
  logic [9:0] duty_cmd = '0;
  logic [15:0] rdata, w;
  logic rvalid, rerr;
  logic [9:0] duty_out, fl, ex;
  prot_cfg_t prot;
  drive_cfg_t drive;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] ot_tab [4] = '{8'h00, OT_CLAMP_1A, OT_CLAMP_1A6, OT_CLAMP_2A};
  logic [7:0] lk_tab [4] = '{LOCK_2A5, LOCK_1A9, LOCK_1A5, LOCK_0A9};
  logic [9:0] cmds [8] = '{10'h000, 10'h00e, 10'h00f, 10'h031, 10'h032, 10'h063, 10'h064,
    10'h3e8};
  always #12.5 clk_i = ~clk_i;
  motor_protect_drive_config_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .rerr_o(rerr), .duty_cmd_i(duty_cmd),
    .duty_out_o(duty_out), .prot_o(prot), .drive_o(drive));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    req = '{a, d, 1'b1, 1'b0};
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic err);
    @(negedge clk_i);
    req = '{a, 16'h0000, 1'b0, 1'b1};
    @(negedge clk_i);
    req.rd = 1'b0;
    check("read answer", {14'h0, rvalid, rerr}, {14'h0, 1'b1, err});
    check("read data", rdata, exp);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    rd(PROT_ADDR, PROT_RESET, 1'b0);
    rd(DRIVE_ADDR, DRIVE_RESET, 1'b0);
    wr(8'h96, 16'hffff);
    rd(8'h96, 16'h0000, 1'b1);
    rd(DRIVE_ADDR, 16'h0000, 1'b0);
    $display("test reset and map done");
    for (int k = 0; k < 16; k++) begin
      w = {k[1:0], 6'(1 << (k % 6)), k[3:0], k[2:0], k[3]};
      wr(PROT_ADDR, w);
      rd(PROT_ADDR, w, 1'b0);
      check("ot clamp", {7'h0, prot.ot_clamp_on, prot.ot_clamp_dA},
        {7'h0, k[1:0] != 0, ot_tab[k[1:0]]});
      check("arms", {10'h0, prot.closed_loop_stuck_arm, prot.open_loop_stuck_arm,
        prot.absent_motor_arm, prot.torque_const_fault_arm, prot.speed_fault_arm,
        prot.lock_current_arm}, {10'h0, w[13:8]});
      check("sw limit", {7'h0, prot.sw_limit_on, prot.sw_limit_dA}, {7'h0, k != 0, 8'(k * 2)});
      check("lock limit", {8'h0, prot.lock_limit_dA},
        {8'h0, k[3] ? 8'((k[2:0] + 1) * 4) : lk_tab[k[1:0]]});
    end
    $display("test protection word done");
    for (int k = 0; k < 8; k++) begin
      w = {k[0], k[1], k[1:0], k[2], k[0], k[1], k[2], k[0], k[2:0], k[1:0], k[1:0]};
      wr(DRIVE_ADDR, w);
      rd(DRIVE_ADDR, w, 1'b0);
      check("drive flags", {9'h0, drive.speed_input_pwm, drive.output_pwm_50k,
        drive.inductive_surge_guard_on, drive.mechanical_surge_guard_on,
        drive.mechanical_surge_to_24v, drive.release_hiz, drive.closed_loop_inhibit},
        {9'h0, w[15:14], w[11:7]});
      check("torque", {8'h0, drive.torque_high_q, drive.torque_low_q},
        {8'h0, k[0] ? TQ_HIGH_2 : TQ_HIGH_3_2, k[1] ? TQ_LOW_1_2 : TQ_LOW_3_4});
      check("ramp", {12'h0, drive.ramp_immediate, drive.closed_loop_ramp},
        {12'h0, k == 0, 3'(k)});
      fl = k[0] ? DUTY_FLOOR_10 : DUTY_FLOOR_5;
      check("duty and edge", {3'h0, drive.duty_floor, drive.duty_low_full, drive.phase_edge_rate},
        {3'h0, fl, k[1], k[1:0]});
      for (int j = 0; j < 8; j++) begin
        @(negedge clk_i);
        duty_cmd = cmds[j];
        @(negedge clk_i);
        ex = cmds[j] < DUTY_CUTOFF ? (k[1] ? DUTY_FULL : 10'h000) : (cmds[j] < fl ? fl : cmds[j]);
        check("duty out", {6'h0, duty_out}, {6'h0, ex});
      end
    end
    $display("test drive word done");
    // Write while disabled must not land
    @(negedge clk_i);
    ce_i = 1'b0;
    wr(DRIVE_ADDR, 16'h1234);
    @(negedge clk_i);
    ce_i = 1'b1;
    rd(DRIVE_ADDR, w, 1'b0);
    $display("test clock enable done");
    final_report();
  end
endmodule
